// File: design/psm_defines.vh
// psm_defines.vh: register map, reset values, scheme codes, timing
// assumes: included by the modulator and its rate generator only
`ifndef PSM_DEFINES_VH
`define PSM_DEFINES_VH

// ==========================================================
// register byte offsets
`define PSM_OFS_CTRL     8'h00
`define PSM_OFS_BAUD     8'h04
`define PSM_OFS_MARKER   8'h08
`define PSM_OFS_CARRIER  8'h0c
`define PSM_OFS_DCLR     8'h10
`define PSM_OFS_DATA     8'h14
`define PSM_OFS_USER     8'h18
`define PSM_OFS_STATUS   8'h1c

// ==========================================================
// control fields
`define PSM_CTRL_SCHEME  2:0
`define PSM_CTRL_CARR    3
`define PSM_CTRL_RUN     4
`define PSM_CTRL_UBITS   7:5

// ==========================================================
// scheme codes
`define PSM_SCH_BPSK     3'h0
`define PSM_SCH_QPSK     3'h1
`define PSM_SCH_OQPSK    3'h2
`define PSM_SCH_DQPSK    3'h3
`define PSM_SCH_8PSK     3'h4
`define PSM_SCH_16PSK    3'h5
`define PSM_SCH_USER     3'h6

// ==========================================================
// reset values and limits
`define PSM_RST_CTRL     8'h28
`define PSM_RST_BAUD     24'h002710
`define PSM_BAUD_MAX     24'h989680
`define PSM_RST_MARKER   12'h001
`define PSM_MARKER_MAX   12'hfa0
`define PSM_RST_CARRIER  32'h0a3d70a4
`define PSM_CLK_HZ       32'h017d7840
`define PSM_CHAR_ZERO    8'h30
`define PSM_CHAR_ONE     8'h31
`define PSM_PH_QUARTER   16'h4000
`define PSM_PH_EIGHTH    16'h2000

`endif

// File: design/psm_rate_gen.v
// psm_rate_gen.v: fractional rate generator, one tick per modulus
// assumes: i_inc below the modulus, one clock, synchronous reset
`timescale 1ns/100ps
`include "psm_defines.vh"

module psm_rate_gen
#(
    parameter W = 32
)
(
    input  wire         i_sys_clk,
    input  wire         i_srst,
    input  wire         i_en,
    input  wire [W-1:0] i_inc,
    input  wire [W-1:0] i_mod,
    output reg          o_tick
);

    reg  [W-1:0] acc_r;
    wire [W:0]   sum = {1'b0, acc_r} + {1'b0, i_inc};

    // ==========================================================
    // accumulate the rate, wrap at the modulus and tick
    always @(posedge i_sys_clk)
    begin
        if (i_srst || !i_en)
        begin
            acc_r  <= {W{1'b0}};
            o_tick <= 1'b0;
        end
        else if (sum >= {1'b0, i_mod})
        begin
            acc_r  <= sum[W-1:0] - i_mod;
            o_tick <= 1'b1;
        end
        else
        begin
            acc_r  <= sum[W-1:0];
            o_tick <= 1'b0;
        end
    end

endmodule // psm_rate_gen

// File: design/psm_modulator.v
// psm_modulator.v: phase keying symbol engine with an apb register file
// assumes: 25 MHz clock, apb master on the same clock, sine lookup after o_phase
//
// How it works
// - binary shifts between 0 and 180 degrees
// - quadrature takes two bits, four phases
// - offset quadrature moves in-phase, then quadrature
// - pi/4 differential adds rotation to current
// - 16-phase codes 0000..1111 pick vectors in order
// - one symbol per baud interval, table order
// - bit 0 start phase, 1 shifted
// - sine carrier finishes its cycle before stopping
// - data loaded as ascii 0 and 1
// - sync pulse at marker index 1..4000
// - one marker, default 1, readable
// - scheme defaults to binary, readable
// - baud 1 to 10e6 hz, default 10e3
// - carrier enable default on, off gives baseband
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/100ps
`include "psm_defines.vh"

module psm_modulator
#(
    parameter AW = 14
)
(
    input  wire        i_sys_clk,
    input  wire        i_srst,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [7:0]  i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output wire        o_pready,
    output wire        o_pslverr,
    output reg  [15:0] o_phase,
    output reg  [15:0] o_sym_phase,
    output reg         o_sync,
    output reg         o_active
);

    localparam DEPTH = 1 << AW;

    reg  [7:0]    ctrl_r;
    reg  [23:0]   baud_r;
    reg  [11:0]   marker_r;
    reg  [31:0]   carr_inc_r;
    reg  [AW:0]   dlen_r;
    reg           bits_mem [0:DEPTH-1];
    reg  [15:0]   user_mem [0:15];
    reg  [31:0]   carr_acc_r;
    reg  [AW-1:0] ptr_r;
    reg  [11:0]   idx_r;
    reg           half_r;
    reg  [1:0]    iq_r;
    reg  [15:0]   sph_r;
    reg  [2:0]    w;
    reg  [3:0]    code;
    reg  [AW-1:0] nptr;
    reg           wrap;
    reg  [15:0]   ph_new;
    reg  [31:0]   rd_val;
    reg           hit;
    integer       k;

    wire [2:0]  scheme  = ctrl_r[`PSM_CTRL_SCHEME];
    wire        carr_en = ctrl_r[`PSM_CTRL_CARR];
    wire        run     = ctrl_r[`PSM_CTRL_RUN];
    wire [2:0]  ubits   = ctrl_r[`PSM_CTRL_UBITS];
    wire        wr_en   = i_psel & i_penable & i_pwrite;
    wire [32:0] carr_sum = {1'b0, carr_acc_r} + {1'b0, carr_inc_r};
    wire        carr_wrap = carr_sum[32];
    wire        sub_tick;
    wire        have_sym = dlen_r >= {{(AW-2){1'b0}}, w};
    wire        start   = run & ~o_active & have_sym;
    wire        advance = o_active & run & sub_tick & half_r;
    wire        mid     = o_active & sub_tick & ~half_r;
    wire        load    = start | advance;
    // stop only at the end of a carrier cycle, or at once without carrier
    wire        stop    = o_active & ~run & (carr_wrap | ~carr_en);

    // ==========================================================
    // apb slave: zero wait, unmapped offsets flag an error
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~hit;

    always @*
    begin
        hit    = 1'b1;
        rd_val = 32'h00000000;
        case (i_paddr)
            `PSM_OFS_CTRL:    rd_val = {24'h000000, ctrl_r};
            `PSM_OFS_BAUD:    rd_val = {8'h00, baud_r};
            `PSM_OFS_MARKER:  rd_val = {20'h00000, marker_r};
            `PSM_OFS_CARRIER: rd_val = carr_inc_r;
            `PSM_OFS_DCLR:    rd_val = {{(31-AW){1'b0}}, dlen_r};
            `PSM_OFS_DATA:    rd_val = 32'h00000000;
            `PSM_OFS_USER:    rd_val = 32'h00000000;
            `PSM_OFS_STATUS:  rd_val = {3'h0, o_active, idx_r, sph_r};
            default:          hit    = 1'b0;
        endcase
    end

    // read data is sampled in the setup phase
    always @(posedge i_sys_clk)
    begin
        if (i_srst)
            o_prdata <= 32'h00000000;
        else if (i_psel & ~i_penable & ~i_pwrite)
            o_prdata <= rd_val;
    end

    // ==========================================================
    // configuration registers
    always @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            ctrl_r     <= `PSM_RST_CTRL;
            baud_r     <= `PSM_RST_BAUD;
            marker_r   <= `PSM_RST_MARKER;
            carr_inc_r <= `PSM_RST_CARRIER;
        end
        else if (wr_en)
        begin
            case (i_paddr)
                `PSM_OFS_CTRL:
                begin
                    ctrl_r[4:0] <= i_pwdata[4:0];
                    // user width kept within 1..4 bits
                    if (i_pwdata[7:5] == 3'h0)
                        ctrl_r[7:5] <= 3'h1;
                    else if (i_pwdata[7:5] > 3'h4)
                        ctrl_r[7:5] <= 3'h4;
                    else
                        ctrl_r[7:5] <= i_pwdata[7:5];
                end
                `PSM_OFS_BAUD:
                begin
                    if (i_pwdata[23:0] == 24'h000000)
                        baud_r <= 24'h000001;
                    else if (i_pwdata[31:24] != 8'h00 ||
                             i_pwdata[23:0] > `PSM_BAUD_MAX)
                        baud_r <= `PSM_BAUD_MAX;
                    else
                        baud_r <= i_pwdata[23:0];
                end
                `PSM_OFS_MARKER:
                begin
                    if (i_pwdata[11:0] == 12'h000)
                        marker_r <= 12'h001;
                    else if (i_pwdata[31:12] != 20'h00000 ||
                             i_pwdata[11:0] > `PSM_MARKER_MAX)
                        marker_r <= `PSM_MARKER_MAX;
                    else
                        marker_r <= i_pwdata[11:0];
                end
                `PSM_OFS_CARRIER:
                    carr_inc_r <= i_pwdata;
                default:
                    ctrl_r <= ctrl_r;
            endcase
        end
    end

    // ==========================================================
    // symbol table loading
    // ascii 0 and 1 append one bit, other characters ignored
    always @(posedge i_sys_clk)
    begin
        if (i_srst)
            dlen_r <= {(AW+1){1'b0}};
        else if (wr_en && i_paddr == `PSM_OFS_DCLR)
            dlen_r <= {(AW+1){1'b0}};
        else if (wr_en && i_paddr == `PSM_OFS_DATA &&
                 (i_pwdata[7:0] == `PSM_CHAR_ZERO ||
                  i_pwdata[7:0] == `PSM_CHAR_ONE) &&
                 dlen_r < DEPTH)
            dlen_r <= dlen_r + 1'b1;
    end

    // table storage, no reset needed
    always @(posedge i_sys_clk)
    begin
        if (wr_en && i_paddr == `PSM_OFS_DATA && !dlen_r[AW])
            bits_mem[dlen_r[AW-1:0]] <= i_pwdata[0];
        // user phase entry, index in bits 19:16
        if (wr_en && i_paddr == `PSM_OFS_USER)
            user_mem[i_pwdata[19:16]] <= i_pwdata[15:0];
    end

    // ==========================================================
    // symbol width per scheme
    always @*
    begin
        case (scheme)
            `PSM_SCH_BPSK:  w = 3'h1;
            `PSM_SCH_QPSK:  w = 3'h2;
            `PSM_SCH_OQPSK: w = 3'h2;
            `PSM_SCH_DQPSK: w = 3'h2;
            `PSM_SCH_8PSK:  w = 3'h3;
            `PSM_SCH_16PSK: w = 3'h4;
            `PSM_SCH_USER:  w = ubits;
            default:        w = 3'h1;
        endcase
    end

    // ==========================================================
    // next symbol position and its code, first bit is msb
    always @*
    begin
        wrap = 1'b0;
        nptr = {AW{1'b0}};
        if (advance)
        begin
            // wrap when no full symbol remains
            if ({1'b0, ptr_r} + {{(AW-3){1'b0}}, w, 1'b0} > dlen_r)
                wrap = 1'b1;
            else
                nptr = ptr_r + {{(AW-3){1'b0}}, w};
        end
        code = 4'h0;
        for (k = 0; k < 4; k = k + 1)
            if (k < w)
                code = {code[2:0], bits_mem[nptr + k[AW-1:0]]};
    end

    // ==========================================================
    // phase of the new symbol, 16 bits per full turn
    always @*
    begin
        case (scheme)
            `PSM_SCH_BPSK:  ph_new = {code[0], 15'h0000};
            `PSM_SCH_QPSK:  ph_new = {code[1:0], 14'h0000} + `PSM_PH_EIGHTH;
            `PSM_SCH_OQPSK: ph_new = {code[1:0], 14'h0000} + `PSM_PH_EIGHTH;
            // first symbol absolute, then relative step
            `PSM_SCH_DQPSK:
                ph_new = start ? {code[1:0], 14'h0000} + `PSM_PH_EIGHTH :
                         sph_r + {code[1:0], 14'h0000} + `PSM_PH_EIGHTH;
            `PSM_SCH_8PSK:  ph_new = {code[2:0], 13'h0000};
            // code n gives vector n in order, n sixteenths of a turn
            `PSM_SCH_16PSK: ph_new = {code, 12'h000};
            `PSM_SCH_USER:  ph_new = user_mem[code];
            default:        ph_new = 16'h0000;
        endcase
    end

    // ==========================================================
    // baud generator at twice the baud rate, two steps per symbol
    // one symbol per baud interval
    psm_rate_gen #(
        .W (32)
    ) u_baud (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_en      (o_active),
        .i_inc     ({7'h00, baud_r, 1'b0}),
        .i_mod     (`PSM_CLK_HZ),
        .o_tick    (sub_tick)
    );

    // ==========================================================
    // playback sequencer
    always @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            o_active <= 1'b0;
            ptr_r    <= {AW{1'b0}};
            idx_r    <= 12'h000;
            half_r   <= 1'b0;
            iq_r     <= 2'b00;
            sph_r    <= 16'h0000;
            o_sync   <= 1'b0;
        end
        else
        begin
            o_sync <= 1'b0;
            if (start)
                o_active <= 1'b1;
            else if (stop)
                o_active <= 1'b0;
            if (mid)
                half_r <= 1'b1;
            else if (load)
                half_r <= 1'b0;
            if (load)
            begin
                ptr_r <= nptr;
                if (start || wrap)
                    idx_r <= 12'h001;
                else
                    idx_r <= idx_r + 12'h001;
                // one pulse at the marker index
                if ((start || wrap) ? marker_r == 12'h001 :
                    marker_r == idx_r + 12'h001)
                    o_sync <= 1'b1;
                // in-phase sign moves on the boundary
                if (scheme == `PSM_SCH_OQPSK)
                begin
                    if (start)
                    begin
                        iq_r  <= {code[0] ^ code[1], code[1]};
                        sph_r <= ph_new;
                    end
                    else
                        iq_r[1] <= code[0] ^ code[1];
                end
                else
                    sph_r <= ph_new;
            end
            // quadrature sign follows half a symbol later
            if (mid && scheme == `PSM_SCH_OQPSK)
                iq_r[0] <= bits_mem[ptr_r];
        end
    end

    // ==========================================================
    // offset quadrature phase from the sign pair, never through zero
    reg [15:0] oq_ph;
    always @*
    begin
        case (iq_r)
            2'b00:   oq_ph = `PSM_PH_EIGHTH;
            2'b10:   oq_ph = `PSM_PH_EIGHTH + `PSM_PH_QUARTER;
            2'b11:   oq_ph = 16'ha000;
            default: oq_ph = 16'he000;
        endcase
    end

    // ==========================================================
    // carrier accumulator and output phase
    always @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            carr_acc_r  <= 32'h00000000;
            o_phase     <= 16'h0000;
            o_sym_phase <= 16'h0000;
        end
        else
        begin
            carr_acc_r <= carr_sum[31:0];
            o_sym_phase <= (scheme == `PSM_SCH_OQPSK) ? oq_ph : sph_r;
            // carrier off gives the symbol phase alone
            if (!carr_en)
                o_phase <= o_active ? o_sym_phase : 16'h0000;
            else if (o_active)
                o_phase <= carr_acc_r[31:16] + o_sym_phase;
            else
                o_phase <= carr_acc_r[31:16];
        end
    end

endmodule // psm_modulator

// File: tb/psm_monitor.sv
// psm_monitor.sv: port-level checks for the phase keying modulator
// assumes: bound into psm_modulator, apb master on i_sys_clk
`timescale 1ns/100ps

module psm_monitor
#(
    parameter AW = 14
)
(
    input wire        i_sys_clk,
    input wire        i_srst,
    input wire        i_psel,
    input wire        i_penable,
    input wire        i_pwrite,
    input wire [7:0]  i_paddr,
    input wire [31:0] i_pwdata,
    input wire [31:0] o_prdata,
    input wire        o_pready,
    input wire        o_pslverr,
    input wire [15:0] o_phase,
    input wire [15:0] o_sym_phase,
    input wire        o_sync,
    input wire        o_active
);
    // ==========
    // shadow of control, marker and loaded bit count
    wire        wr_w  = i_psel && i_penable && i_pwrite;
    wire        bad_w = i_psel && i_penable && (i_paddr > 8'h1c);
    reg  [7:0]  ctrl_r;
    reg  [11:0] mark_r;
    reg  [15:0] bits_r;

    // snoop apb writes
    always @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            ctrl_r <= 8'h28;
            mark_r <= 12'h001;
            bits_r <= 16'h0000;
        end
        else if (wr_w)
        begin
            if (i_paddr == 8'h00)
                ctrl_r <= i_pwdata[7:0];
            if (i_paddr == 8'h08)
                mark_r <= i_pwdata[11:0];
            if (i_paddr == 8'h10)
                bits_r <= 16'h0000;
            if (i_paddr == 8'h14 && i_pwdata[7:1] == 7'h18)
                bits_r <= bits_r + 16'h0001;
        end
    end

    // ==========
    // properties
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_srst);

    property p_unmapped;
        bad_w |-> o_pslverr && o_prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access");
    property p_start;
        wr_w && i_paddr == 8'h00 && i_pwdata[4] && !o_active && bits_r > 16'h3
            |-> ##2 o_active;
    endproperty
    a_start: assert property (p_start) else $error("playback did not start");
    property p_stop;
        wr_w && i_paddr == 8'h00 && !i_pwdata[4] && o_active |-> ##[1:30] !o_active;
    endproperty
    a_stop: assert property (p_stop) else $error("playback did not stop");
    property p_sync_first;
        $rose(o_active) && mark_r == 12'h001 |-> o_sync;
    endproperty
    a_sync_first: assert property (p_sync_first) else $error("no sync at index 1");
    property p_sync_pulse;
        o_sync |-> o_active ##1 !o_sync;
    endproperty
    a_sync_pulse: assert property (p_sync_pulse) else $error("sync not one cycle");
    property p_baseband;
        !ctrl_r[3] && o_active && $past(o_active, 2) |-> o_phase == $past(o_sym_phase);
    endproperty
    a_baseband: assert property (p_baseband) else $error("carrier not suppressed");
    property p_bpsk;
        ctrl_r[2:0] == 3'h0 && o_active && $past(o_active) |-> o_sym_phase[14:0] == 15'h0;
    endproperty
    a_bpsk: assert property (p_bpsk) else $error("binary phase off grid");
    property p_quad;
        ctrl_r[2:1] == 2'h0 && ctrl_r[0] && o_active && $past(o_active)
            |-> o_sym_phase[13:0] == 14'h2000;
    endproperty
    a_quad: assert property (p_quad) else $error("quadrature phase off grid");
    property p_8psk;
        ctrl_r[2:0] == 3'h4 && o_active && $past(o_active) |-> o_sym_phase[12:0] == 13'h0;
    endproperty
    a_8psk: assert property (p_8psk) else $error("8-phase off grid");
    property p_16psk;
        ctrl_r[2:0] == 3'h5 && o_active && $past(o_active) |-> o_sym_phase[11:0] == 12'h0;
    endproperty
    a_16psk: assert property (p_16psk) else $error("16-phase off grid");

    // main scenarios reached
    c_start: cover property ($rose(o_active));
    c_sync: cover property (o_sync);
    c_refuse: cover property (bad_w);
endmodule // psm_monitor

bind psm_modulator psm_monitor #(.AW(AW)) u_mon
(
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_phase(o_phase),
    .o_sym_phase(o_sym_phase), .o_sync(o_sync), .o_active(o_active)
);

// File: tb/psm_host.sv
// psm_host.sv: apb master standing in for the host configuration side
// assumes: one clock shared with the modulator, any number of wait states
`timescale 1ns/100ps

module psm_host
(
    input  wire        i_sys_clk,
    input  wire [31:0] i_prdata,
    input  wire        i_pready,
    input  wire        i_pslverr,
    output reg         o_psel    = 1'b0,
    output reg         o_penable = 1'b0,
    output reg         o_pwrite  = 1'b0,
    output reg  [7:0]  o_paddr   = 8'h00,
    output reg  [31:0] o_pwdata  = 32'h0
);
    reg [31:0] rdata;
    reg        err;

    // ==========
    // one transfer: setup, access held until pready, then release
    task xfer(input [7:0] a, input w, input [31:0] d);
    begin
        @(posedge i_sys_clk);
        o_psel   <= 1'b1;
        o_pwrite <= w;
        o_paddr  <= a;
        o_pwdata <= d;
        @(posedge i_sys_clk);
        o_penable <= 1'b1;
        @(posedge i_sys_clk);
        while (i_pready !== 1'b1)
            @(posedge i_sys_clk);
        rdata = i_prdata;
        err   = i_pslverr;
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
        o_pwdata  <= ~d;
    end
    endtask

    task put_bit(input b);
    begin
        xfer(8'h14, 1'b1, b ? 32'h31 : 32'h30);
    end
    endtask
endmodule // psm_host

// File: tb/psk_symbol_modulator_test.sv
// psk_symbol_modulator_test.sv: self-checking bench with a symbol model
// assumes: psm_host drives apb, psm_monitor bound into the design
`timescale 1ns/100ps

module psk_symbol_modulator_test;
    reg         i_sys_clk = 1'b0;
    reg         i_srst    = 1'b1;
    wire        psel, penable, pwrite, pready, pslverr, sync, active;
    wire [7:0]  paddr;
    wire [31:0] pwdata, prdata;
    wire [15:0] phase, sym;
    reg  [31:0] seed = 32'h0000aa87;
    reg  [15:0] user [0:7];
    reg         bits [0:11];
    integer     err_count = 0;
    integer     check_count = 0;
    integer     cyc = 0;
    integer     sync_at, k, n, s, w, i, j, c, xp, lim;

    psm_host u_host
    (
        .i_sys_clk(i_sys_clk), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr),
        .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
        .o_pwdata(pwdata)
    );
    psm_modulator u_dut
    (
        .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_phase(phase), .o_sym_phase(sym),
        .o_sync(sync), .o_active(active)
    );

    // ==========
    // clock, timeout and marker position tracking
    initial
    begin
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk)
    begin
        cyc = cyc + 1;
        if (sync === 1'b1 && sync_at < 0)
            sync_at = k;
        if (cyc == 20000)
        begin
            $display("timeout");
            err_count = err_count + 1;
            summarize;
        end
    end

    // ==========
    // helpers
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y  = x ^ (x << 13);
            y  = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
        check_count = check_count + 1;
        if (g !== e)
        begin
            err_count = err_count + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    task rdc(input [7:0] a, input [31:0] e, input string nm);
    begin
        u_host.xfer(a, 1'b0, 32'h0);
        chk(nm, e, u_host.rdata);
    end
    endtask
    task summarize;
    begin
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    // ==========
    // main sequence
    initial
    begin
        sync_at = -1;
        k = 0;
        repeat (3) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        rdc(8'h00, 32'h28, "ctrl");
        rdc(8'h04, 32'h2710, "baud");
        rdc(8'h08, 32'h1, "marker");
        rdc(8'h20, 32'h0, "unmapped");
        chk("slverr", 32'h1, u_host.err);
        u_host.xfer(8'h04, 1'b1, 32'h0);
        rdc(8'h04, 32'h1, "baud low");
        u_host.xfer(8'h04, 1'b1, 32'hffffff);
        rdc(8'h04, 32'h989680, "baud high");
        u_host.xfer(8'h08, 1'b1, 32'h1388);
        rdc(8'h08, 32'hfa0, "marker high");
        // rate generator at twice baud gives 25 clocks per symbol, offset split 13 then 12
        u_host.xfer(8'h04, 1'b1, 32'hf4240);
        for (i = 0; i < 8; i = i + 1)
        begin
            seed = xs(seed);
            user[i] = seed[15:0];
            u_host.xfer(8'h18, 1'b1, {12'h0, i[3:0], seed[15:0]});
        end
        $display("register test done");
        for (s = 0; s < 7; s = s + 1)
        begin
            w = (s == 0) ? 1 : (s < 4) ? 2 : (s == 6) ? 3 : s - 1;
            n = 12 / w;
            u_host.xfer(8'h08, 1'b1, s % n + 1);
            u_host.xfer(8'h10, 1'b1, 32'h0);
            u_host.xfer(8'h14, 1'b1, 32'h78);
            for (i = 0; i < 12; i = i + 1)
            begin
                seed = xs(seed);
                bits[i] = seed[3];
                u_host.put_bit(seed[3]);
            end
            rdc(8'h10, 32'd12, "bit count");
            sync_at = -1;
            k = 0;
            u_host.xfer(8'h00, 1'b1, 32'h70 + (s == 0 ? 8 : 0) + s);
            for (k = 0; k <= n; k = k + 1)
            begin
                repeat (k == 0 ? 19 : 25) @(posedge i_sys_clk);
                c = 0;
                for (j = 0; j < w; j = j + 1)
                    c = c * 2 + bits[(k % n) * w + j];
                case (s)
                    0: xp = c ? 32'h8000 : 32'h0;
                    1, 2: xp = c * 32'h4000 + 32'h2000;
                    3: xp = (k == 0 ? 0 : xp) + c * 32'h4000 + 32'h2000;
                    4: xp = c << 13;
                    5: xp = c << 12;
                    default: xp = user[c];
                endcase
                xp = xp & 32'hffff;
                chk("symbol phase", xp, sym);
                // carrier off: the output phase is the symbol phase alone
                if (s != 0)
                    chk("output phase", xp, phase);
            end
            chk("sync index", s % n, sync_at);
            u_host.xfer(8'h00, 1'b1, 32'h60 + (s == 0 ? 8 : 0) + s);
            lim = 0;
            while (active === 1'b1 && lim < 40)
            begin
                @(posedge i_sys_clk);
                lim = lim + 1;
            end
            chk("stop time", 32'h1, lim <= (s == 0 ? 27 : 3));
            $display("scheme %0d test done", s);
        end
        summarize;
    end
endmodule // psk_symbol_modulator_test
